// [verilog/smr_pkg.sv]
// Package: mode register field layout, decode tables and timing constants
package smr_pkg;
  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int unsigned ADDR_W = 19;
  localparam int unsigned MODE_W = 18;
  localparam int unsigned LAT_W = 4;
  localparam int unsigned BURST_W = 4;
  // ----------------------------------------
  // Mode bit positions
  // ----------------------------------------
  localparam int unsigned CFG_LSB = 0;
  localparam int unsigned BURST_LSB = 3;
  localparam int unsigned MUX_BIT = 5;
  localparam int unsigned UNUSED_BIT = 6;
  localparam int unsigned DLL_BIT = 7;
  localparam int unsigned IMP_BIT = 8;
  localparam int unsigned TERM_BIT = 9;
  // Second phase line positions in multiplexed mode
  localparam int unsigned PH2_CFG1 = 3;
  localparam int unsigned PH2_CFG2 = 4;
  localparam int unsigned PH2_UNUSED = 8;
  localparam int unsigned PH2_DLL = 9;
  // ----------------------------------------
  // Reset values and codes
  // ----------------------------------------
  localparam logic [17:0] MODE_RST = 18'h00000;
  localparam logic [1:0] BURST_CODE_2 = 2'h0;
  localparam logic [1:0] BURST_CODE_4 = 2'h1;
  localparam logic [1:0] BURST_CODE_8 = 2'h2;
  localparam logic [3:0] BURST_2 = 4'h2;
  localparam logic [3:0] BURST_4 = 4'h4;
  localparam logic [3:0] BURST_8 = 4'h8;
  localparam logic [2:0] CFG_1A = 3'h0;
  localparam logic [2:0] CFG_1B = 3'h1;
  localparam logic [2:0] CFG_2 = 3'h2;
  localparam logic [2:0] CFG_3 = 3'h3;
  localparam logic [2:0] CFG_4 = 3'h4;
  localparam logic [2:0] CFG_5 = 3'h5;
  // Row cycle and read latency per configuration, non-multiplexed
  localparam logic [3:0] RC_1 = 4'h4;
  localparam logic [3:0] RC_2 = 4'h6;
  localparam logic [3:0] RC_3 = 4'h8;
  localparam logic [3:0] RC_4 = 4'h3;
  localparam logic [3:0] RC_5 = 4'h5;
  localparam logic [3:0] LAT_ONE = 4'h1;
  // Row cycle after write then read, same bank, configuration 4
  localparam logic [3:0] RC_4_WR = 4'h4;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_MHZ = 20;
  localparam int unsigned DLL_LOCK_CYC = 1024;
  // ----------------------------------------
  // Capture state
  // ----------------------------------------
  typedef enum logic [0:0] {SMR_IDLE, SMR_PHASE2} smr_state_type;
endpackage

// [verilog/smr_lat_decode.sv]
// Decoder from configuration code and mux mode to cycle and latency counts
module smr_lat_decode (
  // Configuration
  input wire logic [2:0] i_cfg,
  input wire logic i_mux,
  // Counts in clocks, and reserved-code flag
  output logic [smr_pkg::LAT_W-1:0] o_rc,
  output logic [smr_pkg::LAT_W-1:0] o_rl,
  output logic [smr_pkg::LAT_W-1:0] o_wl,
  output logic o_reserved
);
  import smr_pkg::*;
  logic [LAT_W-1:0] base_w;
  logic [LAT_W-1:0] add_w;
  always_comb begin
    case (i_cfg)
      CFG_1A, CFG_1B: base_w = RC_1;
      CFG_2: base_w = RC_2;
      CFG_3: base_w = RC_3;
      CFG_4: base_w = RC_4;
      CFG_5: base_w = RC_5;
      default: base_w = '0;
    endcase
  end
  assign o_reserved = (i_cfg == 3'h6) || (i_cfg == 3'h7);
  // Latency one clock longer in multiplexed mode
  assign add_w = i_mux ? LAT_ONE : '0;
  assign o_rc = base_w;
  assign o_rl = o_reserved ? '0 : base_w + add_w;
  assign o_wl = o_reserved ? '0 : base_w + add_w + LAT_ONE;
endmodule

// [verilog/smr_mode_reg.sv]
// Mode register captured from address inputs on mode-register-set commands
module smr_mode_reg (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Command and address pins
  input wire logic i_mode_register_set_command,
  input wire logic [smr_pkg::ADDR_W-1:0] i_addr,
  // Decoded settings
  output logic [smr_pkg::MODE_W-1:0] o_mode_bits,
  output logic [2:0] o_cfg,
  output logic [smr_pkg::BURST_W-1:0] o_burst_len,
  output logic o_burst_invalid,
  output logic o_address_mux_select,
  output logic o_on_die_termination_enable,
  output logic o_impedance_source_select,
  output logic o_dll_enable,
  output logic o_dll_reset_n,
  output logic [smr_pkg::LAT_W-1:0] o_row_cycle_time,
  output logic [smr_pkg::LAT_W-1:0] o_row_cycle_wr_rd,
  output logic [smr_pkg::LAT_W-1:0] o_read_latency_clocks,
  output logic [smr_pkg::LAT_W-1:0] o_write_latency_clocks,
  output logic o_cfg_reserved
);
  import smr_pkg::*;
  // ----------------------------------------
  // Reset synchroniser
  // ----------------------------------------
  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end
  // ----------------------------------------
  // Capture sequencing
  // ----------------------------------------
  smr_state_type state_q;
  smr_state_type state_d;
  logic [MODE_W-1:0] mode_q;
  logic [MODE_W-1:0] mode_d;
  logic [MODE_W-1:0] ph1_q;
  logic [MODE_W-1:0] ph1_d;
  logic [MODE_W-1:0] nonmux_w;
  logic [MODE_W-1:0] mux_w;
  logic mux_mode_w;
  logic first_phase_w;
  logic second_phase_w;
  // Mode in force decides how a command is read, not the incoming bit 5
  assign mux_mode_w = mode_q[MUX_BIT];
  assign first_phase_w = i_mode_register_set_command && mux_mode_w && state_q == SMR_IDLE;
  assign second_phase_w = state_q == SMR_PHASE2;
  // Upper bits latched as given; controller keeps them low
  assign nonmux_w = i_addr[MODE_W-1:0];
  // Bit 6 is unused: stored as zero in either mode
  always_comb begin
    mux_w = ph1_q;
    mux_w[UNUSED_BIT] = 1'b0;
    mux_w[CFG_LSB+1] = i_addr[PH2_CFG1];
    mux_w[CFG_LSB+2] = i_addr[PH2_CFG2];
    mux_w[DLL_BIT] = i_addr[PH2_DLL];
  end
  always_comb begin
    state_d = state_q;
    ph1_d = ph1_q;
    mode_d = mode_q;
    case (state_q)
      SMR_IDLE: begin
        if (first_phase_w) begin
          ph1_d = i_addr[MODE_W-1:0];
          state_d = SMR_PHASE2;
        end else if (i_mode_register_set_command) begin
          mode_d = nonmux_w;
          mode_d[UNUSED_BIT] = 1'b0;
        end
      end
      SMR_PHASE2: begin
        // Second phase is the next edge, whatever the command pins show
        mode_d = mux_w;
        state_d = SMR_IDLE;
      end
      default: state_d = SMR_IDLE;
    endcase
  end
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= SMR_IDLE;
      ph1_q <= MODE_RST;
      mode_q <= MODE_RST;
    end else begin
      state_q <= state_d;
      ph1_q <= ph1_d;
      mode_q <= mode_d;
    end
  end
  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  logic [2:0] cfg_w;
  logic [1:0] burst_code_w;
  logic [BURST_W-1:0] burst_w;
  logic burst_bad_w;
  logic [LAT_W-1:0] rc_w;
  logic [LAT_W-1:0] rl_w;
  logic [LAT_W-1:0] wl_w;
  logic [LAT_W-1:0] rc_wr_w;
  logic res_w;
  assign cfg_w = mode_q[CFG_LSB +: 3];
  assign burst_code_w = mode_q[BURST_LSB +: 2];
  assign burst_w = (burst_code_w == BURST_CODE_2) ? BURST_2 :
    (burst_code_w == BURST_CODE_4) ? BURST_4 :
    (burst_code_w == BURST_CODE_8) ? BURST_8 : '0;
  // Burst of 8 not offered with configurations 1 and 4; code 11 reserved
  assign burst_bad_w = (burst_code_w == 2'h3) || ((burst_code_w == BURST_CODE_8) &&
    (cfg_w == CFG_1A || cfg_w == CFG_1B || cfg_w == CFG_4));
  // Config 4 relies on a longer gap only for write then read
  assign rc_wr_w = (cfg_w == CFG_4) ? RC_4_WR : rc_w;
  smr_lat_decode u_dec (
    .i_cfg(cfg_w),
    .i_mux(mux_mode_w),
    .o_rc(rc_w),
    .o_rl(rl_w),
    .o_wl(wl_w),
    .o_reserved(res_w)
  );
  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_mode_bits <= MODE_RST;
      o_cfg <= CFG_1A;
      o_burst_len <= BURST_2;
      o_burst_invalid <= 1'b0;
      o_address_mux_select <= 1'b0;
      o_on_die_termination_enable <= 1'b0;
      o_impedance_source_select <= 1'b0;
      o_dll_enable <= 1'b0;
      o_dll_reset_n <= 1'b0;
      o_row_cycle_time <= RC_1;
      o_row_cycle_wr_rd <= RC_1;
      o_read_latency_clocks <= RC_1;
      o_write_latency_clocks <= RC_1 + LAT_ONE;
      o_cfg_reserved <= 1'b0;
    end else begin
      o_mode_bits <= mode_q;
      o_cfg <= cfg_w;
      o_burst_len <= burst_w;
      o_burst_invalid <= burst_bad_w;
      o_address_mux_select <= mode_q[MUX_BIT];
      o_on_die_termination_enable <= mode_q[TERM_BIT];
      o_impedance_source_select <= mode_q[IMP_BIT];
      o_dll_enable <= mode_q[DLL_BIT];
      o_dll_reset_n <= mode_q[DLL_BIT];
      o_row_cycle_time <= rc_w;
      o_row_cycle_wr_rd <= rc_wr_w;
      o_read_latency_clocks <= rl_w;
      o_write_latency_clocks <= wl_w;
      o_cfg_reserved <= res_w;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  nonmux_capture_a: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    (i_mode_register_set_command && !mux_mode_w && state_q == SMR_IDLE) |-> ##2
    (o_mode_bits[MODE_W-1:UNUSED_BIT+1] == $past(i_addr[MODE_W-1:UNUSED_BIT+1], 2) &&
    o_mode_bits[UNUSED_BIT-1:0] == $past(i_addr[UNUSED_BIT-1:0], 2)))
    else $error("non-multiplexed capture wrong");
  mux_phase_a: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    first_phase_w |=> ##2 (o_mode_bits[DLL_BIT] == $past(i_addr[PH2_DLL], 2) &&
    o_mode_bits[CFG_LSB+2:CFG_LSB+1] == $past({i_addr[PH2_CFG2], i_addr[PH2_CFG1]}, 2) &&
    o_mode_bits[TERM_BIT] == $past(ph1_q[TERM_BIT], 1)))
    else $error("multiplexed phase mapping wrong");
  unused_zero_a: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    !o_mode_bits[UNUSED_BIT]) else $error("unused bit stored");
  latency_gap_a: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    !o_cfg_reserved |-> o_write_latency_clocks == o_read_latency_clocks + LAT_ONE)
    else $error("write latency not read plus one");
  mux_latency_a: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    (!o_cfg_reserved && o_address_mux_select) |->
    o_read_latency_clocks == o_row_cycle_time + LAT_ONE)
    else $error("mux latency not raised");
  nonmux_latency_a: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    (o_cfg == CFG_3 && !o_address_mux_select) |-> o_read_latency_clocks == RC_3)
    else $error("config 3 latency wrong");
  burst_bad_a: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    (o_cfg == CFG_4 && o_burst_len == BURST_8) |-> o_burst_invalid)
    else $error("burst 8 in config 4 not flagged");
  dll_follow_a: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    o_dll_enable == o_dll_reset_n && o_dll_enable == o_mode_bits[DLL_BIT])
    else $error("loop control mismatch");
  flags_follow_a: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    o_on_die_termination_enable == o_mode_bits[TERM_BIT] &&
    o_impedance_source_select == o_mode_bits[IMP_BIT])
    else $error("flag outputs mismatch");
  phase2_once_a: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    second_phase_w |=> state_q == SMR_IDLE) else $error("phase two held");
  mux_write_c: cover property (@(posedge i_clk) disable iff (!rst_n_q) first_phase_w);
  enter_mux_c: cover property (@(posedge i_clk) disable iff (!rst_n_q)
    $rose(o_address_mux_select));
  dll_on_c: cover property (@(posedge i_clk) disable iff (!rst_n_q) $rose(o_dll_enable));
  cfg4_c: cover property (@(posedge i_clk) disable iff (!rst_n_q) o_cfg == CFG_4);
endmodule

// [sim/smr_ctrl_model.sv]
// Controller model issuing mode-register-set commands on the address pins
module smr_ctrl_model #(
  parameter int RECOVERY_CYC = 4
) (
  // Clock
  input wire logic i_clk,
  // Command and address pins
  output logic o_cmd,
  output logic [smr_pkg::ADDR_W-1:0] o_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  import smr_pkg::*;

  initial begin
    o_cmd = 1'b0;
    o_addr = 19'h00000;
  end

  // ----------------------------------------
  // Mode write, single or two phase
  // ----------------------------------------
  // No reads or row traffic issued, so lock wait and row cycle hold
  // Reserved codes sent only when a scenario asks for them
  task automatic mode_write(input logic [17:0] m, input logic two);
    logic [18:0] ph1;
    logic [18:0] ph2;
    ph1 = {9'h000, m[9:8], 2'b00, m[5:3], 2'b00, m[0]};
    // Unused line 8 driven high so a leak into bit 6 shows
    ph2 = {9'h000, m[7], 1'b1, 3'b000, m[2:1], 3'b000};
    @(posedge i_clk);
    #2;
    o_cmd = 1'b1;
    // Bit 18 high in single phase: it must be ignored
    o_addr = two ? ph1 : {1'b1, 8'h00, m[9:0]};
    if (two) begin
      @(posedge i_clk);
      #2;
      o_cmd = 1'b0;
      o_addr = ph2;
    end
    @(posedge i_clk);
    #2;
    o_cmd = 1'b0;
    // Released lines show the inverse so a stale value cannot match
    o_addr = ~o_addr;
    repeat (RECOVERY_CYC) @(posedge i_clk);
  endtask
endmodule

// [sim/testbench.sv]
// Testbench for the mode register: writes through the controller model
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import smr_pkg::*;
`define CHK(n, e, g) check(n, 18'(e), 18'(g))

  logic i_clk;
  logic i_nrst;
  logic cmd;
  logic [ADDR_W-1:0] addr;
  logic [MODE_W-1:0] o_mode_bits;
  logic [2:0] o_cfg;
  logic [BURST_W-1:0] o_burst_len;
  logic o_burst_invalid, o_amux, o_term, o_imp, o_dll_en, o_dll_rn, o_rsv;
  logic [LAT_W-1:0] o_rc, o_rc_wr, o_rl, o_wl;
  int failures = 0;
  int cmp_count = 0;

  smr_mode_reg uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_mode_register_set_command(cmd),
    .i_addr(addr), .o_mode_bits(o_mode_bits), .o_cfg(o_cfg), .o_burst_len(o_burst_len),
    .o_burst_invalid(o_burst_invalid), .o_address_mux_select(o_amux),
    .o_on_die_termination_enable(o_term), .o_impedance_source_select(o_imp),
    .o_dll_enable(o_dll_en), .o_dll_reset_n(o_dll_rn), .o_row_cycle_time(o_rc),
    .o_row_cycle_wr_rd(o_rc_wr), .o_read_latency_clocks(o_rl),
    .o_write_latency_clocks(o_wl), .o_cfg_reserved(o_rsv));
  smr_ctrl_model ctl (.i_clk(i_clk), .o_cmd(cmd), .o_addr(addr));

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic check(input string n, input logic [17:0] e, input logic [17:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic verify(input logic [17:0] m);
    logic [2:0] c;
    logic [1:0] b;
    logic x;
    logic rsv;
    logic [3:0] rc;
    logic [3:0] rl;
    c = m[2:0];
    b = m[4:3];
    x = m[5];
    rsv = c[2] & c[1];
    rc = (c == CFG_2) ? RC_2 : (c == CFG_3) ? RC_3 : (c == CFG_4) ? RC_4 :
      (c == CFG_5) ? RC_5 : RC_1;
    if (rsv) rc = 4'h0;
    rl = rsv ? 4'h0 : rc + {3'h0, x};
    #1;
    `CHK("mode", m & 18'h3FFBF, o_mode_bits);
    `CHK("cfg", c, o_cfg);
    `CHK("burst", (b == 2'h3) ? 4'h0 : (4'h2 << b), o_burst_len);
    `CHK("burst_bad", b == 2'h3 || (b == 2'h2 && (c < 3'h2 || c == CFG_4)), o_burst_invalid);
    `CHK("amux", x, o_amux);
    `CHK("term", m[9], o_term);
    `CHK("imp", m[8], o_imp);
    `CHK("dll", {m[7], m[7]}, {o_dll_en, o_dll_rn});
    `CHK("rc", rc, o_rc);
    `CHK("rl", rl, o_rl);
    `CHK("wl", rsv ? 4'h0 : rl + 4'h1, o_wl);
    `CHK("rsv", rsv, o_rsv);
    if (!rsv) `CHK("rc_wr", (c == CFG_4) ? RC_4_WR : rc, o_rc_wr);
  endtask

  function automatic logic [17:0] build(input logic [3:0] k, input logic x);
    return {8'h00, k[0], k[1], k[3], 1'b1, x, k[3:2], k[2:0]};
  endfunction

  task automatic wr(input logic [17:0] m, input logic two);
    ctl.mode_write(m, two);
    verify(m);
  endtask

  task automatic do_reset();
    @(posedge i_clk);
    #2;
    i_nrst = 1'b0;
    repeat (4) @(posedge i_clk);
    #2;
    i_nrst = 1'b1;
    repeat (3) @(posedge i_clk);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    i_nrst = 1'b0;
    do_reset();
    verify(18'h00000);
    $display("test reset_defaults done");
    for (int i = 0; i < 16; i++) wr(build(4'(i), 1'b0), 1'b0);
    wr(18'h00014, 1'b0);
    $display("test single_phase_codes done");
    wr(18'h00080, 1'b0);
    wr(18'h00000, 1'b0);
    wr(18'h00080, 1'b0);
    $display("test loop_reset done");
    wr(18'h00020, 1'b0);
    for (int i = 0; i < 16; i++) wr(build(4'(i), 1'b1), 1'b1);
    $display("test two_phase_codes done");
    wr(18'h00386, 1'b1);
    wr(18'h0030A, 1'b0);
    $display("test leave_mux done");
    wr(18'h00221, 1'b0);
    do_reset();
    verify(18'h00000);
    wr(18'h00105, 1'b0);
    $display("test mid_run_reset done");
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    failures++;
    give_verdict();
  end
endmodule
